// >>> sbm_pkg.sv
`default_nettype none
package sbm_pkg;
  localparam int unsigned sbm_aw = 13;
  // byte-relative layout inside the secure window
  localparam logic [12:0] sbm_ram4_base = 13'h0000;
  localparam logic [12:0] sbm_ram1_base = 13'h1000;
  localparam logic [12:0] sbm_bank_base = 13'h1400;
  localparam logic [12:0] sbm_bank_end = 13'h1420;
  localparam logic [12:0] sbm_ctrl_off = 13'h1800;
  localparam logic [12:0] sbm_key_off = 13'h1804;
  localparam logic [12:0] sbm_stat_off = 13'h1808;
  localparam logic [31:0] sbm_window_base = 32'hF8044000;
  localparam int unsigned sbm_ram4_words = 1024;
  localparam int unsigned sbm_ram1_words = 256;
  localparam int unsigned sbm_bank_words = 8;
  localparam int unsigned sbm_slow_div = 4;
  // control bits
  localparam int unsigned sbm_ctrl_scr_dis = 0;
  localparam int unsigned sbm_ctrl_auto_backup_flag = 1;
  // status bits
  localparam int unsigned sbm_stat_scramble_on_flag = 0;
  localparam int unsigned sbm_stat_auto_backup_flag = 1;
  localparam int unsigned sbm_stat_erasing = 2;
  localparam logic [31:0] sbm_lfsr_seed = 32'hACE1_2468;
  localparam logic [31:0] sbm_lfsr_taps = 32'h8020_0003;
  typedef enum logic [3:0] {
    sbm_idle = 4'h1,
    sbm_wait = 4'h2,
    sbm_done = 4'h4,
    sbm_erase = 4'h8
  } sbm_state_t;
endpackage
`default_nettype wire

// >>> sbm_rng.sv
`default_nettype none
module sbm_rng (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // free-running random word, internal only
  output logic [31:0] rnd
);
  import sbm_pkg::*;
  logic [31:0] next_rnd;
  always_comb begin
    next_rnd = {rnd[30:0], ^(rnd & sbm_lfsr_taps)};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rnd <= sbm_lfsr_seed;
    end else begin
      rnd <= next_rnd;
    end
  end
endmodule
`default_nettype wire

// >>> sbm_secure_backup_memory.sv
// Summary of operation
// - An intrusion erases the whole 4 Kbyte erasable backup RAM.
// - The 1 Kbyte retained backup RAM is never erased by hardware.
// - The 256-bit register bank is cleared completely on intrusion.
// - All regions accept byte, halfword and word reads and writes.
// - Regions sit at base, base plus 0x1000 and base plus 0x1400.
// - Memory transfers run at one quarter of the normal bus rate.
// - All stored data is scrambled and descrambled on reads.
// - After reset scrambling is on and a key is generated by hardware.
// - Software may write a new key, which is used from then on.
// - Software may turn scrambling off through the control register.
// - The internal random source is never readable by software.
// - A read-only status bit shows whether scrambling is enabled.
// - A read-only status bit shows whether automatic backup is enabled.
`default_nettype none
module sbm_secure_backup_memory #(
  // storage depths in words
  parameter int unsigned ram4_depth = sbm_pkg::sbm_ram4_words,
  parameter int unsigned ram1_depth = sbm_pkg::sbm_ram1_words,
  parameter int unsigned bank_depth = sbm_pkg::sbm_bank_words,
  // memory transfer rate divider
  parameter int unsigned slow_div = sbm_pkg::sbm_slow_div
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbm_pkg::sbm_aw-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // intrusion indication
  input wire logic intrusion,
  // status
  output logic erase_busy
);
  import sbm_pkg::*;

  logic [31:0] ram4 [ram4_depth];
  logic [31:0] ram1 [ram1_depth];
  logic [31:0] bank [bank_depth];

  logic [31:0] rnd;
  sbm_rng u_rng (
    .clk(clk),
    .rst(rst),
    .rnd(rnd)
  );

  sbm_state_t state, next_state;
  logic [31:0] key, next_key;
  logic key_valid, next_key_valid;
  logic scr_dis, next_scr_dis;
  logic auto_backup_flag, next_auto_backup_flag;
  logic [1:0] div_cnt, next_div_cnt;
  logic [9:0] ers_idx, next_ers_idx;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic intr_pend, next_intr_pend;

  // decode
  logic in_ram4, in_ram1, in_bank, is_ctrl, is_key, is_stat, is_mem;
  logic [31:0] wmask, rd_raw, wr_old, wr_word, cur_key;
  logic [9:0] widx;
  logic slow_tick, access, mem_we, erase_lock;

  always_comb begin
    in_ram4 = 1'b0;
    in_ram1 = 1'b0;
    in_bank = 1'b0;
    is_ctrl = 1'b0;
    is_key = 1'b0;
    is_stat = 1'b0;
    if (paddr < sbm_ram1_base) begin
      in_ram4 = 1'b1;
    end else if (paddr < sbm_bank_base) begin
      in_ram1 = 1'b1;
    end else if (paddr < sbm_bank_end) begin
      in_bank = 1'b1;
    end else if (paddr[12:2] == sbm_ctrl_off[12:2]) begin
      is_ctrl = 1'b1;
    end else if (paddr[12:2] == sbm_key_off[12:2]) begin
      is_key = 1'b1;
    end else if (paddr[12:2] == sbm_stat_off[12:2]) begin
      is_stat = 1'b1;
    end
    is_mem = in_ram4 | in_ram1 | in_bank;
    widx = paddr[11:2];
  end

  // byte lane mask for narrow writes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = pwrite ? {8{pstrb[gi]}} : 8'h00;
    end
  endgenerate

  // key in use: zero when scrambling is off
  assign cur_key = scr_dis ? 32'h0000_0000 : key;

  always_comb begin
    rd_raw = 32'h0000_0000;
    if (in_ram4) begin
      rd_raw = ram4[widx];
    end else if (in_ram1) begin
      rd_raw = ram1[widx[7:0]];
    end else if (in_bank) begin
      rd_raw = bank[widx[2:0]];
    end
    wr_old = rd_raw ^ cur_key ^ {22'h0, widx};
    wr_word = (((wr_old & ~wmask) | (pwdata & wmask)) ^ cur_key) ^ {22'h0, widx};
    if (scr_dis) begin
      wr_old = rd_raw;
      wr_word = (rd_raw & ~wmask) | (pwdata & wmask);
    end
  end

  // memory accesses wait for a quarter-rate slot
  assign slow_tick = (div_cnt == 2'(slow_div - 1));
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
    if (slow_tick) begin
      next_div_cnt = 2'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ram4 and bank stay locked until the exit state has passed, so that the
  // read word captured one cycle before the answer is already the cleared one
  assign erase_lock = (state == sbm_erase) || (state == sbm_done);
  assign access = psel & penable;
  always_comb begin
    pready = 1'b0;
    if (access) begin
      // register accesses answer in their first access cycle
      if (!is_mem) begin
        pready = 1'b1;
      end else if (erase_lock && (in_ram4 || in_bank)) begin
        // a locked region keeps the master waiting
        pready = 1'b0;
      end else begin
        pready = slow_tick;
      end
    end
  end
  assign mem_we = access & pready & pwrite & is_mem;

  // configuration and key
  always_comb begin
    next_key = key;
    next_key_valid = key_valid;
    next_scr_dis = scr_dis;
    next_auto_backup_flag = auto_backup_flag;
    // key taken once from the random source, never routed to prdata
    if (!key_valid) begin
      next_key = rnd;
      next_key_valid = 1'b1;
    end
    if (access && pready && pwrite) begin
      if (is_ctrl) begin
        next_scr_dis = pwdata[sbm_ctrl_scr_dis];
        next_auto_backup_flag = pwdata[sbm_ctrl_auto_backup_flag];
      end else if (is_key) begin
        // a written key wins over a generated one taken in the same cycle
        next_key = pwdata;
        next_key_valid = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      key <= 32'h0000_0000;
      key_valid <= 1'b0;
      scr_dis <= 1'b0;
      auto_backup_flag <= 1'b0;
    end else begin
      key <= next_key;
      key_valid <= next_key_valid;
      scr_dis <= next_scr_dis;
      auto_backup_flag <= next_auto_backup_flag;
    end
  end

  // intrusion erase sequencer; an intrusion mid-erase queues one more pass
  always_comb begin
    next_state = state;
    next_ers_idx = ers_idx;
    next_intr_pend = intr_pend | intrusion;
    case (state)
      sbm_idle: begin
        next_state = sbm_wait;
      end
      sbm_wait: begin
        if (intr_pend) begin
          next_state = sbm_erase;
          next_ers_idx = 10'h000;
          next_intr_pend = intrusion;
        end
      end
      sbm_erase: begin
        next_ers_idx = ers_idx + 10'h001;
        if (ers_idx == 10'(ram4_depth - 1)) begin
          next_state = sbm_done;
        end
      end
      sbm_done: begin
        // an intrusion seen in the last erase cycle restarts at once
        next_state = sbm_wait;
        if (intr_pend) begin
          next_state = sbm_erase;
          next_ers_idx = 10'h000;
          next_intr_pend = intrusion;
        end
      end
      default: begin
        next_state = sbm_idle;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sbm_idle;
      ers_idx <= 10'h000;
      intr_pend <= 1'b0;
    end else begin
      state <= next_state;
      ers_idx <= next_ers_idx;
      intr_pend <= next_intr_pend;
    end
  end

  // read data and slave error are captured while the request is pending,
  // so both already stand in the cycle in which pready is high
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel) begin
      // for writes the captured word is simply unused
      next_prdata = 32'h0000_0000;
      if (is_mem) begin
        next_prdata = wr_old;
      end else if (is_ctrl) begin
        next_prdata[sbm_ctrl_scr_dis] = scr_dis;
        next_prdata[sbm_ctrl_auto_backup_flag] = auto_backup_flag;
      end else if (is_key) begin
        next_prdata = 32'h0000_0000;
      end else if (is_stat) begin
        next_prdata[sbm_stat_scramble_on_flag] = ~scr_dis;
        next_prdata[sbm_stat_auto_backup_flag] = auto_backup_flag;
        next_prdata[sbm_stat_erasing] = (state == sbm_erase);
        next_pslverr = pwrite;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // storage arrays, no reset
  always_ff @(posedge clk) begin
    if (state == sbm_erase) begin
      ram4[ers_idx] <= 32'h0000_0000;
      if (ers_idx < 10'(bank_depth)) begin
        bank[ers_idx[2:0]] <= 32'h0000_0000;
      end
      if (mem_we && in_ram1) begin
        ram1[widx[7:0]] <= wr_word;
      end
    end else if (mem_we) begin
      if (in_ram4) begin
        ram4[widx] <= wr_word;
      end else if (in_ram1) begin
        ram1[widx[7:0]] <= wr_word;
      end else begin
        bank[widx[2:0]] <= wr_word;
      end
    end
  end

  assign erase_busy = (state == sbm_erase);
endmodule
`default_nettype wire

// >>> sbm_properties.sv
`default_nettype none
module sbm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbm_pkg::sbm_aw-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // intrusion and status
  input wire logic intrusion,
  input wire logic erase_busy
);
  import sbm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] cnt, next_cnt;
  always_comb next_cnt = erase_busy ? cnt + 12'h1 : 12'h0;
  always_ff @(posedge clk) cnt <= rst ? 12'h0 : next_cnt;
  in_access_a: assert property (pready |-> psel && penable) else $error("early ready");
  quarter_rate_a: assert property (pready && paddr < 13'h1420 |=>
    !(pready && paddr < 13'h1420) [*3]) else $error("memory too fast");
  ram1_bound_a: assert property ($rose(penable) && psel && paddr >= 13'h1000 &&
    paddr < 13'h1400 |-> ##[0:3] pready) else $error("ram1 stalled");
  erase_start_a: assert property (intrusion |-> ##[1:2] erase_busy) else $error("no erase");
  erase_len_a: assert property ($fell(erase_busy) |-> cnt >= 12'h400) else $error("short erase");
  erase_block_a: assert property (psel && penable && erase_busy &&
    (paddr < 13'h1000 || paddr inside {[13'h1400:13'h141F]}) |-> !pready) else $error("erase leak");
  key_hidden_a: assert property (pready && !pwrite && paddr == 13'h1804 |-> prdata == 32'h0)
    else $error("key readable");
  unmapped_err_a: assert property (pready && paddr inside {[13'h1420:13'h17FF]} |-> pslverr)
    else $error("no slave error");
endmodule
bind sbm_secure_backup_memory sbm_checker sbm_checker_i (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .intrusion, .erase_busy);
`default_nettype wire

// >>> sbm_apb_host.sv
`default_nettype none
module sbm_apb_host (
  // clock
  input wire logic clk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [sbm_pkg::sbm_aw-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbm_pkg::*;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er, output logic to);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? s : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    to = pready !== 1'b1;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle keeps two requests apart
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb_secure_backup_memory.sv
`default_nettype none
`define CK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb_secure_backup_memory;
  timeunit 1ns;
  timeprecision 1ps;
  import sbm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, intrusion = 1'b0, psel, penable, pwrite, pready, pslverr, erase_busy, er, to;
  logic [12:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, seed = 32'h06D71FD3;
  logic [3:0] pstrb;
  logic [12:0] bases [3] = '{13'h0000, 13'h1000, 13'h1400};
  int err_total = 0, n_compared = 0;
  always #5 clk = ~clk;
  sbm_secure_backup_memory sbm_secure_backup_memory_i (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .intrusion, .erase_busy);
  sbm_apb_host sbm_apb_host_i (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [12:0] ad, input logic [31:0] d, input logic [3:0] s);
    sbm_apb_host_i.xfer(w, ad, d, s, rd, er, to);
    if (to) begin
      err_total++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, sbm_stat_off, 32'h0, 4'h0);
    `CK(rd, 32'h00000001)
    acc(1'b0, sbm_key_off, 32'h0, 4'h0);
    `CK(rd, 32'h0)
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      a = bases[i % 3] + {6'h0, seed[6:2] & (i % 3 == 2 ? 5'h07 : 5'h1F), 2'b00};
      acc(1'b1, a, seed, 4'hF);
      acc(1'b0, a, 32'h0, 4'h0);
      `CK(rd, seed)
    end
    acc(1'b1, sbm_key_off, lfsr(seed), 4'hF);
    acc(1'b0, a, 32'h0, 4'h0);
    `CK(rd !== seed, 1'b1)
    for (int s = 1; s < 16; s += 5) begin
      seed = lfsr(seed);
      acc(1'b1, 13'h1010, 32'hFFFFFFFF, 4'hF);
      acc(1'b1, 13'h1010, seed, s[3:0]);
      acc(1'b0, 13'h1010, 32'h0, 4'h0);
      `CK(rd, mrg(32'hFFFFFFFF, seed, s[3:0]))
    end
    acc(1'b1, sbm_ctrl_off, 32'h00000003, 4'hF);
    acc(1'b0, sbm_stat_off, 32'h0, 4'h0);
    `CK(rd, 32'h00000002)
    acc(1'b1, sbm_stat_off, 32'h0, 4'hF);
    `CK(er, 1'b1)
    acc(1'b0, 13'h1500, 32'h0, 4'h0);
    `CK({er, rd}, 33'h100000000)
    acc(1'b1, 13'h0040, 32'hA5A5A5A5, 4'hF);
    acc(1'b1, 13'h1040, 32'h5A5A5A5A, 4'hF);
    acc(1'b1, 13'h1404, 32'h12345678, 4'hF);
    intrusion <= 1'b1;
    @(posedge clk);
    intrusion <= 1'b0;
    repeat (3) @(posedge clk);
    `CK(erase_busy, 1'b1)
    acc(1'b0, 13'h1040, 32'h0, 4'h0);
    `CK({erase_busy, rd}, 33'h15A5A5A5A)
    acc(1'b0, sbm_stat_off, 32'h0, 4'h0);
    `CK(rd, 32'h00000006)
    acc(1'b0, 13'h0040, 32'h0, 4'h0);
    `CK(rd, 32'h0)
    acc(1'b0, 13'h1404, 32'h0, 4'h0);
    `CK(rd, 32'h0)
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, sbm_stat_off, 32'h0, 4'h0);
    `CK(rd, 32'h00000001)
    acc(1'b1, sbm_ctrl_off, 32'h00000001, 4'hF);
    acc(1'b0, 13'h1040, 32'h0, 4'h0);
    `CK(rd, 32'h5A5A5A5A)
    print_verdict();
  end
endmodule
`default_nettype wire
